// ---- core/lpm_ctrl.sv ----
// Low-power mode controller with boot selection and APB register slave
`timescale 1ns/1ps
module lpm_ctrl (
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Core side
	input  wire logic        core_sleep_req,
	input  wire logic        any_irq_event,
	input  wire logic [21:0] wake_lines,
	// Standby wake sources
	input  wire logic        external_reset_pin_n,
	input  wire logic        rtc_event,
	input  wire logic        free_running_watchdog_rst,
	input  wire logic        standby_wakeup_pin,
	// Supply monitor and boot straps
	input  wire logic        low_voltage_detector,
	input  wire logic [1:0]  boot_pins,
	input  wire logic        opt_bank_sel,
	// Power and clock controls, boot selection and interrupt
	output logic             core_clk_en,
	output logic             periph_clk_en,
	output logic             domain_clk_en,
	output logic             internal_rc_high_speed_en,
	output logic             external_high_speed_crystal_en,
	output logic             pll_en,
	output logic             core_voltage_regulator_en,
	output logic             domain_pwr_en,
	output logic             retain_en,
	output logic             sysclk_sel_irc,
	output logic             domain_reset_n,
	output logic [1:0]       boot_src,
	output logic             boot_bank,
	output logic             irq
);
	lpm_pkg::lpm_state_t st_q, st_d;
	logic [1:0]  mode_q, mode_d;
	logic [1:0]  msk_q, msk_d;
	logic [1:0]  ist_q, ist_d;
	logic [21:0] wken_q, wken_d;
	logic [31:0] bkp_q, bkp_d;
	logic [31:0] rdata_d;
	logic        rdy_q, rdy_d;
	logic        err_d;
	logic [7:0]  cnt_q, cnt_d;
	logic        strap_q;
	logic [1:0]  boot_q;
	logic        bank_q;
	logic        lvd_lvl, lvd_rise;
	logic        wk_lvl, wk_rise;
	logic        wr_acc, rd_acc, hit, acc_ph;
	logic        deep_wake, stby_wake;
	logic [12:0] ctl_d, ctl_q;

	// Pin wake source and supply warning cross in through synchronisers
	lpm_sync_edge u_wkpin (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (standby_wakeup_pin),
		.level   (wk_lvl),
		.rise    (wk_rise)
	);
	lpm_sync_edge u_lvd (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (low_voltage_detector),
		.level   (lvd_lvl),
		.rise    (lvd_rise)
	);

	// Read data and error are prepared in the first access cycle (one wait state);
	// a write lands only at the edge where the master sees pready high
	assign acc_ph    = psel & penable & ~rdy_q;
	assign wr_acc    = psel & penable & pwrite & rdy_q;
	assign rd_acc    = acc_ph & ~pwrite;
	assign deep_wake = |(wake_lines & wken_q);
	// Reset pin is active low; any of the four sources ends standby
	assign stby_wake = ~external_reset_pin_n | rtc_event | free_running_watchdog_rst
		| wk_rise;

	// Address decode, register writes and read mux
	always_comb begin
		mode_d  = mode_q;
		msk_d   = msk_q;
		wken_d  = wken_q;
		bkp_d   = bkp_q;
		rdata_d = 32'h00000000;
		rdy_d   = psel & penable & ~rdy_q;
		hit     = 1'b1;
		case (paddr)
			lpm_pkg::LPM_CTRL_OFS: begin
				rdata_d[1:0] = mode_q;
				if (wr_acc) begin
					mode_d = pwdata[lpm_pkg::LPM_CTRL_MODE_LSB +: lpm_pkg::LPM_CTRL_WIDTH];
				end
			end
			lpm_pkg::LPM_STAT_OFS: begin
				rdata_d[2:0] = st_q;
				rdata_d[4:3] = boot_q;
				rdata_d[5]   = bank_q;
				rdata_d[6]   = lvd_lvl;
				rdata_d[7]   = wk_lvl;
			end
			lpm_pkg::LPM_INTST_OFS: begin
				rdata_d[1:0] = ist_q;
			end
			lpm_pkg::LPM_INTMSK_OFS: begin
				rdata_d[1:0] = msk_q;
				if (wr_acc) begin
					msk_d = pwdata[1:0];
				end
			end
			lpm_pkg::LPM_WKEN_OFS: begin
				rdata_d[21:0] = wken_q;
				if (wr_acc) begin
					wken_d = pwdata[21:0];
				end
			end
			lpm_pkg::LPM_BKP_OFS: begin
				rdata_d = bkp_q;
				if (wr_acc) begin
					bkp_d = pwdata;
				end
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		err_d = acc_ph & ~hit;
		if (!rd_acc) begin
			rdata_d = 32'h00000000;
		end
	end

	// Sticky interrupt status; a new event beats a write-one clear
	always_comb begin
		ist_d = ist_q;
		if (wr_acc && paddr == lpm_pkg::LPM_INTST_OFS) begin
			ist_d = ist_q & ~pwdata[1:0];
		end
		if (lvd_rise) begin
			ist_d[lpm_pkg::LPM_IRQ_LVD] = 1'b1;
		end
		// Wake-done flag marks the last settle cycle
		if (st_q == lpm_pkg::LPM_WAKE && cnt_q == 8'h00) begin
			ist_d[lpm_pkg::LPM_IRQ_WAKE] = 1'b1;
		end
	end

	// Mode sequencer: entry on the core sleep request, exit on wake sources
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		case (st_q)
			lpm_pkg::LPM_RUN: begin
				if (core_sleep_req) begin
					case (mode_q)
						lpm_pkg::LPM_SEL_DEEP: st_d = lpm_pkg::LPM_DEEP;
						lpm_pkg::LPM_SEL_STBY: st_d = lpm_pkg::LPM_STBY;
						default:               st_d = lpm_pkg::LPM_SLEEP;
					endcase
				end
			end
			lpm_pkg::LPM_SLEEP: begin
				if (any_irq_event | deep_wake) begin
					st_d = lpm_pkg::LPM_RUN;
				end
			end
			lpm_pkg::LPM_DEEP: begin
				if (deep_wake) begin
					st_d  = lpm_pkg::LPM_WAKE;
					cnt_d = 8'h00;
				end
			end
			lpm_pkg::LPM_STBY: begin
				if (stby_wake) begin
					st_d  = lpm_pkg::LPM_WAKE;
					cnt_d = 8'(lpm_pkg::LPM_SETTLE_CYC);
				end
			end
			lpm_pkg::LPM_WAKE: begin
				if (cnt_q == 8'h00) begin
					st_d = lpm_pkg::LPM_RUN;
				end else begin
					cnt_d = cnt_q - 8'h01;
				end
			end
			default: begin
				st_d = lpm_pkg::LPM_RUN;
			end
		endcase
	end

	// Output control word decoded from the next state
	always_comb begin
		// core,periph,dom,irc,hxt,pll,reg,pwr,ret,sel_irc,rstn
		ctl_d = {ctl_q[12:11], 11'b11111111111};
		case (st_d)
			lpm_pkg::LPM_SLEEP: begin
				ctl_d[10] = 1'b0;
			end
			lpm_pkg::LPM_DEEP: begin
				// Clocks and fast oscillators stop, state held
				ctl_d[10:5] = {1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
			end
			lpm_pkg::LPM_STBY: begin
				// Domain and regulator off, contents dropped
				ctl_d[10:0] = 11'b00000000000;
			end
			lpm_pkg::LPM_WAKE: begin
				ctl_d[10:9] = 2'b00;
				ctl_d[0]    = (st_q != lpm_pkg::LPM_STBY) & ctl_q[0];
				ctl_d[6:5]  = 2'b00;
			end
			default: begin
			end
		endcase
		// Deep-sleep, standby and the wake state force the internal RC clock
		if (st_d != lpm_pkg::LPM_RUN && st_d != lpm_pkg::LPM_SLEEP) begin
			ctl_d[1] = 1'b1;
		end else if (wr_acc && paddr == lpm_pkg::LPM_CTRL_OFS) begin
			ctl_d[1] = pwdata[2];
		end else begin
			ctl_d[1] = ctl_q[1];
		end
		// Apart from the reset value of the control word, fast crystal and PLL may only run when the system is not on the RC
		if (st_d == lpm_pkg::LPM_RUN || st_d == lpm_pkg::LPM_SLEEP) begin
			ctl_d[6:5] = {~ctl_d[1], ~ctl_d[1]};
		end
		ctl_d[12:11] = 2'b00;
	end

	// State registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q   <= lpm_pkg::LPM_RUN;
			cnt_q  <= 8'h00;
			mode_q <= lpm_pkg::LPM_CTRL_RST;
			msk_q  <= lpm_pkg::LPM_MSK_RST;
			ist_q  <= 2'h0;
			wken_q <= lpm_pkg::LPM_WKEN_RST;
			bkp_q  <= lpm_pkg::LPM_BKP_RST;
			prdata <= 32'h00000000;
			rdy_q  <= 1'b0;
			pslverr <= 1'b0;
			// Domain powered and on the RC clock while reset is held
			ctl_q  <= 13'h0FFB;
			irq    <= 1'b0;
		end else begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			mode_q <= (st_d == lpm_pkg::LPM_STBY) ? lpm_pkg::LPM_CTRL_RST : mode_d;
			msk_q  <= (st_d == lpm_pkg::LPM_STBY) ? lpm_pkg::LPM_MSK_RST : msk_d;
			ist_q  <= ist_d;
			wken_q <= (st_d == lpm_pkg::LPM_STBY) ? lpm_pkg::LPM_WKEN_RST : wken_d;
			bkp_q  <= bkp_d; // Backup register survives standby
			prdata <= rdata_d;
			rdy_q  <= rdy_d;
			pslverr <= err_d;
			ctl_q  <= ctl_d;
			irq    <= |(ist_d & msk_d);
		end
	end

	// Boot straps caught once, the first edge after reset release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_q <= 1'b0;
			boot_q  <= lpm_pkg::LPM_BOOT_FLASH;
			bank_q  <= 1'b0;
		end else if (!strap_q) begin
			strap_q <= 1'b1;
			// Code 10 is a second flash code; bank 1 only with flash boot
			boot_q  <= (boot_pins == 2'b10) ? lpm_pkg::LPM_BOOT_FLASH : boot_pins;
			bank_q  <= opt_bank_sel & (boot_pins[0] == 1'b0);
		end
	end

	assign pready                         = rdy_q;
	assign core_clk_en                    = ctl_q[10];
	assign periph_clk_en                  = ctl_q[9];
	assign domain_clk_en                  = ctl_q[8];
	assign internal_rc_high_speed_en      = ctl_q[7];
	assign external_high_speed_crystal_en = ctl_q[6];
	assign pll_en                         = ctl_q[5];
	assign core_voltage_regulator_en      = ctl_q[4];
	assign domain_pwr_en                  = ctl_q[3];
	assign retain_en                      = ctl_q[2];
	assign sysclk_sel_irc                 = ctl_q[1];
	assign domain_reset_n                 = ctl_q[0];
	assign boot_src                       = boot_q;
	assign boot_bank                      = bank_q;
endmodule // lpm_ctrl

// ---- include/lpm_pkg.sv ----
// Package with register map, field positions, reset values and enums of the power-mode controller
//
// Functional notes
// - In sleep only the core clock is gated; peripheral clocks keep running.
// - Any interrupt or event while in sleep returns the device to run.
// - Entering deep-sleep stops every clock of the core-voltage domain.
// - Deep-sleep disables the internal RC, the external crystal and the PLL.
// - Deep-sleep keeps SRAM and register contents, with no other activity in the domain.
// - Deep-sleep ends on any enabled line of the external interrupt controller.
// - On leaving deep-sleep the internal RC becomes the system clock.
// - Standby powers off the core domain and its regulator and disables all fast oscillators.
// - Standby loses SRAM and registers except the backup-domain registers; the code also keeps the interrupt status.
// - Standby ends only on reset pin, RTC event, watchdog reset or wakeup pin rising edge.
// - Boot pins sampled at startup select flash, system memory or SRAM, flash by default.
// - Flash boot uses bank 0 unless the option-byte bank bit is set, then bank 1.
// - A low-voltage detector crossing raises a warning interrupt.
package lpm_pkg;
	// Register byte offsets
	localparam logic [11:0] LPM_CTRL_OFS   = 12'h000;
	localparam logic [11:0] LPM_STAT_OFS   = 12'h004;
	localparam logic [11:0] LPM_INTST_OFS  = 12'h008;
	localparam logic [11:0] LPM_INTMSK_OFS = 12'h00C;
	localparam logic [11:0] LPM_WKEN_OFS   = 12'h010;
	localparam logic [11:0] LPM_BKP_OFS    = 12'h014;
	// Control fields
	localparam int LPM_CTRL_MODE_LSB = 0;
	localparam int LPM_CTRL_WIDTH    = 2;
	// Interrupt status bit positions
	localparam int LPM_IRQ_LVD  = 0;
	localparam int LPM_IRQ_WAKE = 1;
	localparam int LPM_IRQ_N    = 2;
	// Wakeup lines: 16 external plus 6 internal sources
	localparam int LPM_EXT_N    = 22;
	// Reset values
	localparam logic [1:0]  LPM_CTRL_RST   = 2'h0;
	localparam logic [1:0]  LPM_MSK_RST    = 2'h0;
	localparam logic [21:0] LPM_WKEN_RST   = 22'h3FFFFF;
	localparam logic [31:0] LPM_BKP_RST    = 32'h00000000;
	// Regulator settle time after standby wake
	localparam int LPM_SETTLE_NS  = 1000;
	localparam int LPM_CLK_NS     = 100;
	localparam int LPM_SETTLE_CYC = (LPM_SETTLE_NS + LPM_CLK_NS - 1) / LPM_CLK_NS;

	// Target mode selected by software
	typedef enum logic [1:0] {
		LPM_SEL_SLEEP = 2'b00,
		LPM_SEL_DEEP  = 2'b01,
		LPM_SEL_STBY  = 2'b10
	} lpm_sel_t;

	// Controller states
	typedef enum logic [2:0] {
		LPM_RUN   = 3'b000,
		LPM_SLEEP = 3'b001,
		LPM_DEEP  = 3'b010,
		LPM_STBY  = 3'b011,
		LPM_WAKE  = 3'b100
	} lpm_state_t;

	// Boot sources
	typedef enum logic [1:0] {
		LPM_BOOT_FLASH = 2'b00,
		LPM_BOOT_SYS   = 2'b01,
		LPM_BOOT_SRAM  = 2'b11
	} lpm_boot_t;
endpackage

// ---- core/lpm_sync_edge.sv ----
// Two-flop synchroniser with a rising-edge pulse output
`timescale 1ns/1ps
module lpm_sync_edge (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic din,
	output logic      level,
	output logic      rise
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	// First flop feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= din;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise  = sync_q & ~last_q;
endmodule // lpm_sync_edge

// ---- testbench/lpm_core_model.sv ----
// Processor core and wakeup-source model facing the power-mode controller
`timescale 1ns/1ps
module lpm_core_model (
	input  wire logic        pclk,
	input  wire logic        go,
	input  wire logic [2:0]  src,
	input  wire logic [4:0]  line,
	output logic             core_sleep_req = 1'h0,
	output logic             any_irq_event = 1'h0,
	output logic [21:0]      wake_lines = 22'h0,
	output logic             external_reset_pin_n = 1'h1,
	output logic             rtc_event = 1'h0,
	output logic             free_running_watchdog_rst = 1'h0,
	output logic             standby_wakeup_pin = 1'h0
);
	// One source at a time, held only while go stays high
	always @(posedge pclk) begin
		core_sleep_req <= go && src == 3'h0;
		any_irq_event <= go && src == 3'h1;
		wake_lines <= (go && src == 3'h2) ? 22'h1 << line : 22'h0;
		external_reset_pin_n <= !(go && src == 3'h3);
		rtc_event <= go && src == 3'h4;
		free_running_watchdog_rst <= go && src == 3'h5;
		standby_wakeup_pin <= go && src == 3'h6;
	end
endmodule // lpm_core_model

// ---- testbench/lpm_ctrl_asserts.sv ----
// Port-level checks of the power-mode controller
`timescale 1ns/1ps
module lpm_ctrl_asserts (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        core_sleep_req,
	input wire logic        any_irq_event,
	input wire logic        core_clk_en,
	input wire logic        periph_clk_en,
	input wire logic        domain_clk_en,
	input wire logic        internal_rc_high_speed_en,
	input wire logic        external_high_speed_crystal_en,
	input wire logic        pll_en,
	input wire logic        core_voltage_regulator_en,
	input wire logic        domain_pwr_en,
	input wire logic        retain_en,
	input wire logic        sysclk_sel_irc,
	input wire logic        domain_reset_n,
	input wire logic [1:0]  boot_src,
	input wire logic        boot_bank
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Domain must stay in reset while the regulator settles
	sequence s_held;
		!domain_reset_n [*8];
	endsequence
	sequence s_up;
		##[1:4] core_clk_en;
	endsequence
	// Domain clock already on the cycle before keeps the one-cycle deep wake out
	a_sleep_periph: assert property (
		!core_clk_en && domain_clk_en && domain_reset_n && $past(domain_clk_en)
		|-> periph_clk_en)
		else $error("peripheral clock stopped in sleep");
	a_sleep_wake: assert property (
		!core_clk_en && domain_clk_en && domain_reset_n && any_irq_event |-> s_up)
		else $error("sleep not left on event");
	a_deep_osc: assert property (
		$fell(domain_clk_en) && domain_pwr_en |-> !internal_rc_high_speed_en
		&& !external_high_speed_crystal_en && !pll_en && retain_en)
		else $error("deep entry left clocks running");
	a_deep_irc: assert property (
		$rose(domain_clk_en) && $past(retain_en) |-> ##[0:2] sysclk_sel_irc)
		else $error("deep exit not on RC");
	a_stby_off: assert property (
		$fell(domain_pwr_en) |-> (!core_voltage_regulator_en
		&& !internal_rc_high_speed_en && !external_high_speed_crystal_en && !pll_en) [*3])
		else $error("standby left supply on");
	a_stby_hold: assert property (
		$rose(domain_pwr_en) |-> s_held)
		else $error("domain reset released early");
	// Request is seen one edge before the clock enable drops
	a_req_first: assert property (
		$fell(core_clk_en) |-> $past(core_sleep_req))
		else $error("low power without request");
	a_bank_flash: assert property (
		boot_bank |-> boot_src == 2'h0)
		else $error("bank set without flash boot");
endmodule // lpm_ctrl_asserts

bind lpm_ctrl lpm_ctrl_asserts u_chk (.pclk, .presetn, .core_sleep_req, .any_irq_event,
	.core_clk_en, .periph_clk_en, .domain_clk_en, .internal_rc_high_speed_en,
	.external_high_speed_crystal_en, .pll_en, .core_voltage_regulator_en, .domain_pwr_en,
	.retain_en, .sysclk_sel_irc, .domain_reset_n, .boot_src, .boot_bank);

// ---- testbench/low_power_mode_controller_tb_top.sv ----
// Self-checking bench of the power-mode controller
`timescale 1ns/1ps
module low_power_mode_controller_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, bad, go;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, bkp;
	logic        core_sleep_req, any_irq_event, external_reset_pin_n, rtc_event;
	logic        free_running_watchdog_rst, standby_wakeup_pin, low_voltage_detector;
	logic [21:0] wake_lines;
	logic [1:0]  boot_pins, boot_src;
	logic        opt_bank_sel, core_clk_en, periph_clk_en, domain_clk_en, pll_en, irq;
	logic        internal_rc_high_speed_en, external_high_speed_crystal_en, boot_bank;
	logic        core_voltage_regulator_en, domain_pwr_en, retain_en, sysclk_sel_irc;
	logic        domain_reset_n;
	logic [2:0]  src;
	logic [4:0]  line;
	logic [15:0] r;
	logic [31:0] bkp_exp[$];
	int          err_total, compares, i, k;
	wire  [4:0]  deep_v = {domain_clk_en, internal_rc_high_speed_en,
		external_high_speed_crystal_en, pll_en, retain_en};
	wire  [4:0]  stby_v = {domain_pwr_en, core_voltage_regulator_en,
		internal_rc_high_speed_en, pll_en, external_high_speed_crystal_en};

	lpm_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .core_sleep_req, .any_irq_event, .wake_lines,
		.external_reset_pin_n, .rtc_event, .free_running_watchdog_rst,
		.standby_wakeup_pin, .low_voltage_detector, .boot_pins, .opt_bank_sel,
		.core_clk_en, .periph_clk_en, .domain_clk_en, .internal_rc_high_speed_en,
		.external_high_speed_crystal_en, .pll_en, .core_voltage_regulator_en,
		.domain_pwr_en, .retain_en, .sysclk_sel_irc, .domain_reset_n, .boot_src,
		.boot_bank, .irq);
	lpm_core_model u_core (.pclk, .go, .src, .line, .core_sleep_req, .any_irq_event,
		.wake_lines, .external_reset_pin_n, .rtc_event, .free_running_watchdog_rst,
		.standby_wakeup_pin);

	// Clock of 100 ns period
	initial begin
		pclk = 1'h0;
		forever #50 pclk = ~pclk;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	// Idle cycle first, so back-to-back calls never drive psel twice at one edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		rd = prdata;
		bad = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 50) err_total++;
	endtask

	task automatic fire(input logic [2:0] s, input int n);
		src <= s;
		go <= 1'h1;
		cyc(n);
		go <= 1'h0;
	endtask

	task wrap_up;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// Watchdog well beyond the expected few hundred cycles
	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		wrap_up;
	end

	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, go, src, line} = '0;
		{low_voltage_detector, opt_bank_sel, boot_pins} = '0;
		presetn = 1'h0;
		r = 16'h7F49;
		// Straps are sampled again at every reset release
		for (i = 0; i < 4; i++) begin
			r = lfsr(r);
			presetn <= 1'h0;
			boot_pins <= i[1:0];
			opt_bank_sel <= r[0];
			cyc(i == 0 ? 12 : 2);
			presetn <= 1'h1;
			cyc(3);
			chk("boot_src", boot_src, (i == 2) ? 0 : i);
			chk("boot_bank", boot_bank, r[0] & ~i[0]);
		end
		apb(1'h0, 12'h018, 32'h0);
		chk("miss_err", bad, 1'h1);
		chk("miss_data", rd, 32'h0);
		apb(1'h1, 12'h000, 32'h4);
		fire(3'h0, 1);
		cyc(3);
		chk("sleep", {core_clk_en, periph_clk_en}, 2'h1);
		fire(3'h1, 2);
		cyc(3);
		chk("sleep_exit", core_clk_en, 1'h1);
		apb(1'h1, 12'h000, 32'h1);
		cyc(2);
		chk("run_clk", sysclk_sel_irc, 1'h0);
		fire(3'h0, 1);
		cyc(3);
		chk("deep", deep_v, 5'h1);
		r = lfsr(r);
		line <= 5'(r % 22);
		fire(3'h2, 2);
		cyc(4);
		chk("deep_exit", {domain_clk_en, sysclk_sel_irc}, 2'h3);
		// Each standby wake source in turn; a plain interrupt must not wake
		for (k = 3; k < 7; k++) begin
			r = lfsr(r);
			bkp = {r, ~r};
			bkp_exp.push_back(bkp); // Reference copy of the backup word
			apb(1'h1, 12'h014, bkp);
			apb(1'h1, 12'h000, 32'h2);
			fire(3'h0, 1);
			cyc(3);
			fire(3'h1, 3);
			cyc(3);
			chk("stby", stby_v, 5'h0);
			fire(k[2:0], 4);
			i = 0;
			while ((domain_reset_n !== 1'h1 || core_clk_en !== 1'h1) && i < 40) begin
				cyc(1);
				i++;
			end
			chk("stby_exit", domain_pwr_en, 1'h1);
			chk("stby_up", {domain_reset_n, core_clk_en}, 2'h3);
			apb(1'h0, 12'h000, 32'h0);
			chk("ctrl_lost", rd & 32'h3, 32'h0);
			apb(1'h0, 12'h014, 32'h0);
			chk("bkp_kept", rd, bkp_exp.pop_front());
		end
		apb(1'h1, 12'h008, 32'h3);
		apb(1'h1, 12'h00C, 32'h1);
		low_voltage_detector <= 1'h1;
		cyc(6);
		chk("irq_on", irq, 1'h1);
		apb(1'h1, 12'h008, 32'h1);
		cyc(2);
		chk("irq_clr", irq, 1'h0);
		apb(1'h1, 12'h00C, 32'h0);
		low_voltage_detector <= 1'h0;
		cyc(4);
		low_voltage_detector <= 1'h1;
		cyc(6);
		chk("irq_msk", irq, 1'h0);
		apb(1'h0, 12'h008, 32'h0);
		chk("lvd_sticky", rd & 32'h1, 32'h1);
		wrap_up;
	end
endmodule // low_power_mode_controller_tb_top
